// >>> core/rbs_pkg.sv
// Shared constants and types for the read burst sequencer.
// Assumes a 16-bit link word per bus clock cycle and a 2-bit wrap field.
package rbs_pkg;

  // ==========================================================================
  // Command-address layout
  // ==========================================================================
  localparam int CA_CYCLES = 3;
  localparam int CA_W = 48;
  localparam int CA_BURST_TYPE_POS = 45;

  // ==========================================================================
  // Burst wrap field encodings
  // ==========================================================================
  localparam logic [1:0] WRAP_CFG_8_WORDS = 2'h2;
  localparam logic [1:0] WRAP_CFG_16_WORDS = 2'h3;
  localparam logic [1:0] WRAP_CFG_32_WORDS = 2'h1;
  localparam logic [4:0] WRAP_MASK_8 = 5'h07;
  localparam logic [4:0] WRAP_MASK_16 = 5'h0F;
  localparam logic [4:0] WRAP_MASK_32 = 5'h1F;

  // ==========================================================================
  // Page crossing arithmetic
  // ==========================================================================
  localparam int PAGE_WORDS = 16;
  localparam int SUB_PAGE_WORDS = 8;
  localparam logic [5:0] WORD_COUNT_MAX = 6'h3F;

  // ==========================================================================
  // Reset values and link timing
  // ==========================================================================
  localparam logic [4:0] LATENCY_RESET = 5'h10;
  localparam logic [1:0] WRAP_CFG_RESET = 2'h0;
  localparam int LATENCY_MIN = 2;

  typedef enum logic [1:0] {
    RBS_LINEAR = 2'b00,
    RBS_WRAP = 2'b01,
    RBS_HYBRID = 2'b10
  } rbs_mode_t;

  typedef enum logic [2:0] {
    RBS_ST_CA = 3'b000,
    RBS_ST_LAT = 3'b001,
    RBS_ST_DATA = 3'b010,
    RBS_ST_PGIDLE = 3'b011,
    RBS_ST_DONE = 3'b100
  } rbs_state_t;

endpackage

// >>> core/rbs_read_sequencer.sv
// Read-data side of an octal DDR flash link: strobe, burst addresses, page idles.
// Assumes the host drives the link clock and chip select, and that the array
// answers i_mem_data for o_mem_addr within the same link clock cycle.
//
// How it works
// - Device alone drives the read strobe.
// - Strobe edges move together with data.
// - One strobe transition per data word.
// - Strobe quiet until first valid data.
// - Strobe runs on, pausing only page/ECC.
// - ECC stall holds strobe without transitions.
// - Linear, wrapped and hybrid bursts supported.
// - Linear burst increments through whole array.
// - Wrapped burst cycles within aligned group.
// - Burst type bit set forces linear.
// - Wrap field 10 wraps eight words.
// - Wrap field 11 wraps sixteen words.
// - Wrap field 01 wraps thirty-two words.
// - Three CA cycles, then latency, then data.
// - Page idle holds strobe, resumes next page.
// - 32-word wrapped group ends the burst.
// - Latency 16 idles equal sub-page offset.
// - Latency 12 idles offset minus four.
// - Latency 20 idles offset plus four.
// - Idle equals offset minus page plus latency.
// - Hybrid wraps once then continues linearly.
`timescale 1ns/1ps

module rbs_read_sequencer #(
  parameter int ADDR_W = 24
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [1:0] i_wrap_cfg,
  input wire logic i_hybrid_en,
  input wire logic [4:0] i_latency,
  input wire logic i_ecc_stall,
  output logic o_burst_active,
  input wire logic i_link_clk,
  input wire logic i_cs_n,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  output logic o_dq_oe,
  output logic o_ds,
  output logic o_ds_oe,
  output logic [ADDR_W-1:0] o_mem_addr,
  input wire logic [15:0] i_mem_data
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Idle cycles at the first page crossing; negative results clamp to zero.
  function automatic logic [5:0] idle_calc(input logic [2:0] off, input logic [4:0] lat);
    int t;
    t = int'(off) - rbs_pkg::PAGE_WORDS + int'(lat);
    idle_calc = (t > 0) ? 6'(t) : 6'h00;
  endfunction

  // Next word address; a wrap keeps the bits above the group mask.
  function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
                                                  input logic [ADDR_W-1:0] m);
    logic [ADDR_W-1:0] inc;
    inc = a + {{(ADDR_W-1){1'b0}}, 1'b1};
    step_addr = (a & ~m) | (inc & m);
  endfunction

  // ==========================================================================
  // System clock side: configuration capture and activity report
  // ==========================================================================
  logic [1:0] cfg_wrap;
  logic cfg_hybrid;
  logic [4:0] cfg_lat;
  logic act_s1;
  logic act_s2;
  logic [1:0] next_cfg_wrap;
  logic next_cfg_hybrid;
  logic [4:0] next_cfg_lat;
  logic link_active;

  // Configuration is registered here so the link side sees settled levels.
  always_comb begin
    next_cfg_wrap = i_wrap_cfg;
    next_cfg_hybrid = i_hybrid_en;
    next_cfg_lat = (i_latency < 5'(rbs_pkg::LATENCY_MIN)) ? 5'(rbs_pkg::LATENCY_MIN) : i_latency;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cfg_wrap <= rbs_pkg::WRAP_CFG_RESET;
      cfg_hybrid <= 1'b0;
      cfg_lat <= rbs_pkg::LATENCY_RESET;
      act_s1 <= 1'b0;
      act_s2 <= 1'b0;
      o_burst_active <= 1'b0;
    end else begin
      cfg_wrap <= next_cfg_wrap;
      cfg_hybrid <= next_cfg_hybrid;
      cfg_lat <= next_cfg_lat;
      act_s1 <= link_active;
      act_s2 <= act_s1;
      o_burst_active <= act_s2;
    end
  end

  // ==========================================================================
  // Link clock side: synchronisers
  // ==========================================================================
  // Configuration is quasi-static; software must not change it mid-frame.
  logic [7:0] cfg_s1;
  logic [7:0] cfg_s2;
  logic stall_s1;
  logic stall_s2;

  always_ff @(posedge i_link_clk or posedge i_reset) begin
    if (i_reset) begin
      cfg_s1 <= 8'h00;
      cfg_s2 <= 8'h00;
      stall_s1 <= 1'b0;
      stall_s2 <= 1'b0;
    end else begin
      cfg_s1 <= {cfg_hybrid, cfg_wrap, cfg_lat};
      cfg_s2 <= cfg_s1;
      stall_s1 <= i_ecc_stall;
      stall_s2 <= stall_s1;
    end
  end

  logic [4:0] lat_code;
  logic [1:0] wrap_code;
  logic hybrid_code;
  assign lat_code = cfg_s2[4:0];
  assign wrap_code = cfg_s2[6:5];
  assign hybrid_code = cfg_s2[7];

  // ==========================================================================
  // Link clock side: burst sequencer
  // ==========================================================================
  // Chip select high resets the frame asynchronously, so the bus is released
  // even when the host stops the link clock together with chip select.
  logic link_rst;
  assign link_rst = i_reset | i_cs_n;

  rbs_pkg::rbs_state_t state;
  rbs_pkg::rbs_state_t next_state;
  rbs_pkg::rbs_mode_t mode;
  rbs_pkg::rbs_mode_t next_mode;
  logic [31:0] ca;
  logic [31:0] next_ca;
  logic [1:0] ca_cnt;
  logic [1:0] next_ca_cnt;
  logic [4:0] lat_cnt;
  logic [4:0] next_lat_cnt;
  logic [ADDR_W-1:0] mask;
  logic [ADDR_W-1:0] next_mask;
  logic [ADDR_W-1:0] hyb_addr;
  logic [ADDR_W-1:0] next_hyb_addr;
  logic [ADDR_W-1:0] next_mem_addr;
  logic [2:0] off;
  logic [2:0] next_off;
  logic [5:0] idle_left;
  logic [5:0] next_idle_left;
  logic idle_done;
  logic next_idle_done;
  logic [5:0] words;
  logic [5:0] next_words;
  logic [15:0] next_dq;
  logic next_ds;
  logic next_dq_oe;
  logic next_ds_oe;
  logic emit;
  localparam int CA_W_LOCAL = rbs_pkg::CA_W;
  logic [CA_W_LOCAL-1:0] ca_full;
  logic [ADDR_W-1:0] start;
  logic [ADDR_W-1:0] group_len;
  logic [5:0] page_words;

  assign ca_full = {ca, i_dq};
  assign start = ca_full[ADDR_W-1:0];
  assign group_len = mask + {{(ADDR_W-1){1'b0}}, 1'b1};
  assign page_words = 6'(rbs_pkg::PAGE_WORDS) - {3'h0, off};
  assign link_active = (state != rbs_pkg::RBS_ST_CA); // Level, crossed by two flops.

  // Next values for the whole frame: capture, latency, data, idles, wrap.
  always_comb begin
    logic [ADDR_W-1:0] m;
    m = '0;
    next_state = state;
    next_mode = mode;
    next_ca = ca;
    next_ca_cnt = ca_cnt;
    next_lat_cnt = lat_cnt;
    next_mask = mask;
    next_hyb_addr = hyb_addr;
    next_mem_addr = o_mem_addr;
    next_off = off;
    next_idle_left = idle_left;
    next_idle_done = idle_done;
    next_words = words;
    next_dq = o_dq;
    next_ds = o_ds;
    next_dq_oe = o_dq_oe;
    next_ds_oe = o_ds_oe;
    emit = 1'b0;
    unique case (state)
      rbs_pkg::RBS_ST_CA: begin
        next_ca = {ca[15:0], i_dq};
        next_ca_cnt = ca_cnt + 2'h1;
        if (ca_cnt == 2'(rbs_pkg::CA_CYCLES - 1)) begin
          // Mode is decided once per read from the bit, the field and the hybrid enable.
          unique case (wrap_code)
            rbs_pkg::WRAP_CFG_8_WORDS: m = ADDR_W'(rbs_pkg::WRAP_MASK_8);
            rbs_pkg::WRAP_CFG_16_WORDS: m = ADDR_W'(rbs_pkg::WRAP_MASK_16);
            rbs_pkg::WRAP_CFG_32_WORDS: m = ADDR_W'(rbs_pkg::WRAP_MASK_32);
            default: m = '0;
          endcase
          if (ca_full[rbs_pkg::CA_BURST_TYPE_POS] || m == '0) begin
            next_mode = rbs_pkg::RBS_LINEAR;
            next_mask = '0;
          end else if (hybrid_code && m != ADDR_W'(rbs_pkg::WRAP_MASK_32)) begin
            next_mode = rbs_pkg::RBS_HYBRID;
            next_mask = m;
          end else begin
            next_mode = rbs_pkg::RBS_WRAP;
            next_mask = m;
          end
          next_hyb_addr = (start & ~m) + m + {{(ADDR_W-1){1'b0}}, 1'b1};
          next_mem_addr = start;
          next_off = start[2:0]; // Offset within the eight-word sub-page.
          next_idle_left = idle_calc(start[2:0], lat_code);
          next_lat_cnt = lat_code - 5'h1;
          next_ds_oe = 1'b1; // Strobe driven but held low through turnaround.
          next_state = rbs_pkg::RBS_ST_LAT;
        end
      end
      rbs_pkg::RBS_ST_LAT: begin
        next_lat_cnt = lat_cnt - 5'h1;
        if (lat_cnt == 5'h1) begin
          next_state = rbs_pkg::RBS_ST_DATA; // First word at cycle two plus latency.
        end
      end
      rbs_pkg::RBS_ST_DATA: begin
        if (!stall_s2) begin
          emit = 1'b1;
        end
        if (emit) begin
          next_dq = i_mem_data;
          next_ds = ~o_ds;
          next_dq_oe = 1'b1;
          next_words = (words == rbs_pkg::WORD_COUNT_MAX) ? words : words + 6'h1;
          if (mode == rbs_pkg::RBS_LINEAR) begin
            next_mem_addr = o_mem_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
          end else if (mode == rbs_pkg::RBS_HYBRID && ADDR_W'(words) + 1'b1 == group_len) begin
            next_mem_addr = hyb_addr;
          end else if (mode == rbs_pkg::RBS_HYBRID && ADDR_W'(words) + 1'b1 > group_len) begin
            next_mem_addr = o_mem_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
          end else begin
            next_mem_addr = step_addr(o_mem_addr, mask);
          end
          if (mode == rbs_pkg::RBS_WRAP && mask == ADDR_W'(rbs_pkg::WRAP_MASK_32)
              && ADDR_W'(words) + 1'b1 == group_len) begin
            next_state = rbs_pkg::RBS_ST_DONE;
          end else if (!idle_done && words + 6'h1 == page_words) begin
            next_idle_done = 1'b1;
            if (idle_left != 6'h00) begin
              next_state = rbs_pkg::RBS_ST_PGIDLE;
            end
          end
        end
      end
      rbs_pkg::RBS_ST_PGIDLE: begin
        // Data lines keep the last word; the strobe makes no transition.
        next_idle_left = idle_left - 6'h1;
        if (idle_left == 6'h1) begin
          next_state = rbs_pkg::RBS_ST_DATA;
        end
      end
      rbs_pkg::RBS_ST_DONE: begin
        next_dq_oe = 1'b0; // Group delivered; bus released until chip select rises.
        next_ds_oe = 1'b0;
      end
      default: begin
        next_state = rbs_pkg::RBS_ST_CA;
      end
    endcase
  end

  // All sequencer state clears when chip select rises, ready for the next frame; the link synchronisers clear only on reset.
  always_ff @(posedge i_link_clk or posedge link_rst) begin
    if (link_rst) begin
      state <= rbs_pkg::RBS_ST_CA;
      mode <= rbs_pkg::RBS_LINEAR;
      ca <= 32'h00000000;
      ca_cnt <= 2'h0;
      lat_cnt <= 5'h00;
      mask <= '0;
      hyb_addr <= '0;
      o_mem_addr <= '0;
      off <= 3'h0;
      idle_left <= 6'h00;
      idle_done <= 1'b0;
      words <= 6'h00;
      o_dq <= 16'h0000;
      o_ds <= 1'b0;
      o_dq_oe <= 1'b0;
      o_ds_oe <= 1'b0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      ca <= next_ca;
      ca_cnt <= next_ca_cnt;
      lat_cnt <= next_lat_cnt;
      mask <= next_mask;
      hyb_addr <= next_hyb_addr;
      o_mem_addr <= next_mem_addr;
      off <= next_off;
      idle_left <= next_idle_left;
      idle_done <= next_idle_done;
      words <= next_words;
      o_dq <= next_dq;
      o_ds <= next_ds;
      o_dq_oe <= next_dq_oe;
      o_ds_oe <= next_ds_oe;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  // Helper state for the checks only: frame cycle count, idle length, latency.
  logic [7:0] frame_cyc;
  logic [5:0] idle_len;
  logic [5:0] idle_exp;
  logic [4:0] lat_seen;

  always_ff @(posedge i_link_clk or posedge link_rst) begin
    if (link_rst) begin
      frame_cyc <= 8'h00;
      idle_len <= 6'h00;
      idle_exp <= 6'h00;
      lat_seen <= 5'h00;
    end else begin
      frame_cyc <= (frame_cyc == 8'hFF) ? frame_cyc : frame_cyc + 8'h01;
      idle_len <= (state == rbs_pkg::RBS_ST_PGIDLE) ? idle_len + 6'h1 : 6'h00;
      if (state == rbs_pkg::RBS_ST_CA) begin
        idle_exp <= next_idle_left;
        lat_seen <= lat_code;
      end
    end
  end

  property p_ds_only_with_data;
    @(posedge i_link_clk) disable iff (link_rst)
    (o_ds != $past(o_ds)) |-> $past(state) == rbs_pkg::RBS_ST_DATA && $past(!stall_s2);
  endproperty
  a_ds_only_with_data: assert property (p_ds_only_with_data) else $error("strobe moved outside data");

  property p_edge_aligned;
    @(posedge i_link_clk) disable iff (link_rst)
    (o_dq != $past(o_dq)) |-> (o_ds != $past(o_ds));
  endproperty
  a_edge_aligned: assert property (p_edge_aligned) else $error("data moved without strobe");

  property p_one_edge_per_word;
    @(posedge i_link_clk) disable iff (link_rst)
    (state == rbs_pkg::RBS_ST_DATA && !stall_s2) |=> (o_ds != $past(o_ds)) && o_dq_oe;
  endproperty
  a_one_edge_per_word: assert property (p_one_edge_per_word) else $error("word without strobe");

  property p_first_data_time;
    @(posedge i_link_clk) disable iff (link_rst)
    $rose(o_dq_oe) |-> frame_cyc == 8'(lat_seen) + 8'h03;
  endproperty
  a_first_data_time: assert property (p_first_data_time) else $error("first data off latency");

  property p_stall_holds;
    @(posedge i_link_clk) disable iff (link_rst)
    (state == rbs_pkg::RBS_ST_DATA && stall_s2) |=> $stable(o_ds) && $stable(o_dq);
  endproperty
  a_stall_holds: assert property (p_stall_holds) else $error("strobe moved in stall");

  property p_page_idle_place;
    @(posedge i_link_clk) disable iff (link_rst)
    (state == rbs_pkg::RBS_ST_PGIDLE && $past(state) == rbs_pkg::RBS_ST_DATA)
      |-> words == page_words ##1 $stable(o_ds);
  endproperty
  a_page_idle_place: assert property (p_page_idle_place) else $error("page idle misplaced");

  property p_page_idle_len;
    @(posedge i_link_clk) disable iff (link_rst)
    (state == rbs_pkg::RBS_ST_DATA && $past(state) == rbs_pkg::RBS_ST_PGIDLE)
      |-> idle_len == idle_exp;
  endproperty
  a_page_idle_len: assert property (p_page_idle_len) else $error("page idle length wrong");

  property p_wrap_stays_in_group;
    @(posedge i_link_clk) disable iff (link_rst)
    (mode == rbs_pkg::RBS_WRAP && emit) |=> (o_mem_addr & ~mask) == $past(o_mem_addr & ~mask);
  endproperty
  a_wrap_stays_in_group: assert property (p_wrap_stays_in_group) else $error("wrap left group");

  property p_linear_increments;
    @(posedge i_link_clk) disable iff (link_rst)
    (mode == rbs_pkg::RBS_LINEAR && emit) |=> o_mem_addr == $past(o_mem_addr) + 1'b1;
  endproperty
  a_linear_increments: assert property (p_linear_increments) else $error("linear skipped");

  property p_wrap64_ends;
    @(posedge i_link_clk) disable iff (link_rst)
    (state == rbs_pkg::RBS_ST_DONE) |=> !o_dq_oe ##1 (state == rbs_pkg::RBS_ST_DONE && !o_dq_oe);
  endproperty
  a_wrap64_ends: assert property (p_wrap64_ends) else $error("data after wrapped end");

  property p_hybrid_leaves_group;
    @(posedge i_link_clk) disable iff (link_rst)
    (mode == rbs_pkg::RBS_HYBRID && emit && ADDR_W'(words) + 1'b1 == group_len)
      |=> o_mem_addr == hyb_addr;
  endproperty
  a_hybrid_leaves_group: assert property (p_hybrid_leaves_group) else $error("hybrid exit wrong");

  c_page_idle: cover property (@(posedge i_link_clk) disable iff (link_rst)
    state == rbs_pkg::RBS_ST_PGIDLE ##1 state == rbs_pkg::RBS_ST_DATA);
  c_wrap64_done: cover property (@(posedge i_link_clk) disable iff (link_rst)
    state == rbs_pkg::RBS_ST_DONE);
  c_hybrid_exit: cover property (@(posedge i_link_clk) disable iff (link_rst)
    mode == rbs_pkg::RBS_HYBRID && emit && ADDR_W'(words) + 1'b1 == group_len);
  c_stall: cover property (@(posedge i_link_clk) disable iff (link_rst)
    state == rbs_pkg::RBS_ST_DATA && stall_s2);

endmodule

// >>> bench/rbs_host_model.sv
// Host controller model for the link side of the read sequencer.
// Assumes the bench calls its tasks; the link clock runs only when a task runs.
`timescale 1ns/1ps

module rbs_host_model (
  output logic o_link_clk,
  output logic o_cs_n,
  output logic [15:0] o_dq,
  input wire logic [15:0] i_dq,
  input wire logic i_dq_oe,
  input wire logic i_ds,
  input wire logic i_ds_oe
);
  // ==========================================================================
  // Capture state
  // ==========================================================================
  logic [16:0] trace[$];
  int first_edge;
  int bad_oe;

  // Deselected bus with the clock parked low.
  initial begin
    o_link_clk = 1'b0;
    o_cs_n = 1'b1;
    o_dq = 16'hA5A5;
  end

  // One link clock period of 12 ns, rising edge in the middle.
  task automatic tick();
    #6 o_link_clk = 1'b1;
    #6 o_link_clk = 1'b0;
  endtask

  // One read frame; bit 16 of a trace entry marks a quiet strobe cycle between words.
  task automatic frame(input logic [47:0] ca, input int edges);
    logic last_ds;
    int idles;
    trace.delete();
    first_edge = -1;
    bad_oe = 0;
    idles = 0;
    // A few clocks ahead of select let the configuration settle at the link.
    repeat (3) begin
      o_dq = ~o_dq;
      tick();
    end
    last_ds = i_ds;
    o_cs_n = 1'b0;
    for (int e = 0; e < edges; e++) begin
      // Released lines toggle every cycle so that a stale value never passes.
      o_dq = (e < 3) ? ca[47 - 16 * e -: 16] : ~o_dq;
      tick();
      if (i_ds !== last_ds) begin
        if (first_edge < 0) first_edge = e;
        repeat (idles) trace.push_back(17'h10000);
        idles = 0;
        trace.push_back({1'b0, i_dq});
        last_ds = i_ds;
        if (i_dq_oe !== 1'b1 || i_ds_oe !== 1'b1) bad_oe++;
      end else if (first_edge >= 0) idles++;
    end
    o_cs_n = 1'b1;
    #2;
    if (i_ds_oe !== 1'b0 || i_dq_oe !== 1'b0) bad_oe++;
  endtask
endmodule

// >>> bench/tb.sv
// Self-checking bench for the read sequencer with a host model on the link.
// Assumes the array answers combinationally; data is the address xor a random key.
`timescale 1ns/1ps

module tb;
  // ==========================================================================
  // Signals and instances
  // ==========================================================================
  logic i_clk, i_reset, i_hybrid_en, i_ecc_stall, link_clk, cs_n, dq_oe, ds, ds_oe, active;
  logic [1:0] i_wrap_cfg;
  logic [4:0] i_latency;
  logic [15:0] host_dq, dev_dq, key;
  logic [23:0] mem_addr;
  logic [16:0] exp_q[$];
  logic [31:0] r;
  int miscompares, checks, cycles, seed, tnum;

  rbs_read_sequencer #(.ADDR_W(24)) i_rbs_read_sequencer (.i_clk(i_clk), .i_reset(i_reset),
    .i_wrap_cfg(i_wrap_cfg), .i_hybrid_en(i_hybrid_en), .i_latency(i_latency),
    .i_ecc_stall(i_ecc_stall), .o_burst_active(active), .i_link_clk(link_clk),
    .i_cs_n(cs_n), .i_dq(host_dq), .o_dq(dev_dq), .o_dq_oe(dq_oe), .o_ds(ds),
    .o_ds_oe(ds_oe), .o_mem_addr(mem_addr), .i_mem_data(mem_addr[15:0] ^ key));
  rbs_host_model i_rbs_host_model (.o_link_clk(link_clk), .o_cs_n(cs_n), .o_dq(host_dq),
    .i_dq(dev_dq), .i_dq_oe(dq_oe), .i_ds(ds), .i_ds_oe(ds_oe));

  // 200 MHz system clock; a hang is cut short well past the longest expected run.
  initial i_clk = 1'b0;
  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  // ==========================================================================
  // Reporting
  // ==========================================================================
  task automatic miss(input logic [31:0] e, input logic [31:0] g);
    miscompares++;
    $display("wrong value at %0t: expected %h got %h", $time, e, g);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Reference trace per link edge from the first data edge; one page idle per frame.
  task automatic build(input logic [23:0] st, input logic [1:0] cfg, input logic bt, hyb,
                       input int lat, edges);
    logic [23:0] m, a;
    int n, idle, off;
    bit wrap, hy;
    exp_q.delete();
    wrap = !bt && cfg != 2'h0;
    hy = wrap && hyb && cfg != rbs_pkg::WRAP_CFG_32_WORDS;
    m = {19'h0, cfg == rbs_pkg::WRAP_CFG_8_WORDS ? rbs_pkg::WRAP_MASK_8 :
         cfg == rbs_pkg::WRAP_CFG_16_WORDS ? rbs_pkg::WRAP_MASK_16 : rbs_pkg::WRAP_MASK_32};
    off = st[2:0];
    idle = off - rbs_pkg::PAGE_WORDS + lat;
    a = st;
    n = 0;
    for (int e = lat + 2; e < edges; e++) begin
      if (n == rbs_pkg::PAGE_WORDS - off && idle > 0) begin
        exp_q.push_back(17'h10000);
        idle--;
      end else if (wrap && m == 24'h1F && n == 32) break;
      else begin
        exp_q.push_back({1'b0, a[15:0] ^ key});
        n++;
        if (hy && n == m + 1) begin
          a = (st & ~m) + m + 1;
          wrap = 1'b0;
          hy = 1'b0;
        end else if (wrap) a = (a & ~m) | ((a + 1) & m);
        else a = a + 1;
      end
    end
    while (exp_q.size() > 0 && exp_q[$][16]) void'(exp_q.pop_back());
  endtask

  // ==========================================================================
  // One read frame with optional stall, compared word by word
  // ==========================================================================
  task automatic run(input logic [23:0] st, input logic [1:0] cfg, input logic bt, hyb,
                     input int lat, edges, input bit stall);
    logic [16:0] got[$];
    logic act;
    @(posedge i_clk);
    i_wrap_cfg <= cfg;
    i_hybrid_en <= hyb;
    i_latency <= lat[4:0];
    key <= $random(seed);
    repeat (10) @(posedge i_clk);
    build(st, cfg, bt, hyb, lat, edges);
    fork
      i_rbs_host_model.frame({2'h0, bt, 21'h0, st}, edges);
      begin
        repeat (40) @(posedge i_clk);
        act = active;
      end
      if (stall) begin
        repeat (60) @(posedge i_clk);
        i_ecc_stall <= 1'b1;
        repeat (20) @(posedge i_clk);
        i_ecc_stall <= 1'b0;
      end
    join
    checks += 4;
    if (act !== 1'b1) miss(1, act);
    if (i_rbs_host_model.first_edge != lat + 2) miss(lat + 2, i_rbs_host_model.first_edge);
    if (i_rbs_host_model.bad_oe != 0) miss(0, i_rbs_host_model.bad_oe);
    got = i_rbs_host_model.trace;
    // A stall moves words in time but must not drop or repeat any; the words that the
    // stall pushes past the end of the frame are not expected.
    if (stall) begin
      checks++;
      if (got.size() != edges - lat - 2) miss(edges - lat - 2, got.size());
      exp_q = exp_q.find(x) with (x[16] == 1'b0);
      got = got.find(x) with (x[16] == 1'b0);
      while (exp_q.size() > got.size()) void'(exp_q.pop_back());
    end
    if (got.size() != exp_q.size()) miss(exp_q.size(), got.size());
    for (int i = 0; i < exp_q.size() && i < got.size(); i++) begin
      checks++;
      if (got[i] !== exp_q[i]) miss(exp_q[i], got[i]);
    end
    repeat (10) @(posedge i_clk);
    checks++;
    if (active !== 1'b0) miss(0, active);
    tnum++;
    $display("test %0d finished", tnum);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    seed = 85;
    {miscompares, checks, cycles, tnum} = '0;
    {i_reset, i_hybrid_en, i_ecc_stall, i_wrap_cfg, key} = {1'b1, 20'h0};
    i_latency = 5'h10;
    fork
      repeat (4) i_rbs_host_model.tick();
      repeat (12) @(posedge i_clk);
    join
    i_reset <= 1'b0;
    run(24'h000001, 2'h2, 1'b1, 1'b0, 16, 60, 1'b0);
    run(24'h00000C, 2'h2, 1'b0, 1'b0, 16, 50, 1'b0);
    run(24'h00001E, 2'h3, 1'b0, 1'b0, 12, 50, 1'b0);
    run(24'h00002E, 2'h1, 1'b0, 1'b0, 20, 70, 1'b0);
    run(24'h000020, 2'h1, 1'b0, 1'b0, 16, 70, 1'b0);
    run(24'h00000E, 2'h3, 1'b0, 1'b1, 12, 50, 1'b0);
    run(24'h000003, 2'h2, 1'b0, 1'b1, 16, 40, 1'b0);
    run(24'hFFFFF9, 2'h0, 1'b0, 1'b0, 16, 50, 1'b0);
    run(24'h000005, 2'h3, 1'b0, 1'b0, 16, 23, 1'b0);
    run(24'h000004, 2'h0, 1'b0, 1'b0, 16, 70, 1'b1);
    repeat (4) begin
      r = $random(seed);
      run(r[23:0], r[25:24], r[26], r[27], 12 + 4 * (r[29:28] % 3), 60, 1'b0);
    end
    summarize();
  end
endmodule
